// ---- rtl/pwr_irq_pkg.sv ----
// Package: register map, field positions and reset values of the event block
package pwr_irq_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] MAIN_MASK_OFS   = 8'h30;
    localparam logic [7:0] EXTRA_MASK_OFS  = 8'h34;
    localparam logic [7:0] STATUS_OFS      = 8'h38;
    localparam logic [7:0] EXTRA_STAT_OFS  = 8'h3c;
    localparam logic [7:0] EDGE_CFG_OFS    = 8'h40;
    localparam logic [7:0] EVENT_IN_OFS    = 8'h44;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int MAIN_EV_W   = 6;
    localparam int EXTRA_EV_W  = 3;
    localparam int ACT_W       = 11;
    localparam int EDGE_N      = 6;
    localparam int OTHER_BIT   = 7;
    localparam int EDGE_BASE   = 9;
    localparam int EDGE_CFG_W  = 22;

    // Activity input served by each edge slot, and its status bit
    localparam logic [3:0] EDGE_INPUT [EDGE_N] =
        '{4'h1, 4'h5, 4'h7, 4'h8, 4'h9, 4'ha};
    localparam logic [4:0] EDGE_STAT_BIT [EDGE_N] =
        '{5'h09, 5'h0d, 5'h0f, 5'h10, 5'h11, 5'h12};

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [5:0]  MAIN_MASK_RST  = 6'h3b;
    localparam logic [2:0]  EXTRA_MASK_RST = 3'h6;
    localparam logic [21:0] EDGE_CFG_RST   = 22'h000000;

    // Edge selection codes
    localparam logic [1:0] EDGE_NONE    = 2'h0;
    localparam logic [1:0] EDGE_RISE    = 2'h1;
    localparam logic [1:0] EDGE_FALL    = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;

endpackage : pwr_irq_pkg

// ---- rtl/sticky_bits.sv ----
// Sticky event flags with mask gating and write-one-to-clear
`timescale 1ns/1ns
module sticky_bits #(
    parameter int W = 3
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] event_in,
    input  wire logic [W-1:0] mask,
    input  wire logic         clear_wr,
    input  wire logic [W-1:0] clear_data,
    output logic      [W-1:0] flags
);
    logic [W-1:0] next_flags;

    // A fresh event outranks a clear in the same cycle
    always_comb begin
        next_flags = (flags & ~(clear_wr ? clear_data : '0))
                   | (event_in & ~mask);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end
endmodule : sticky_bits

// ---- rtl/edge_detect.sv ----
// Per-input edge detector with a two-bit sensitivity selection
`timescale 1ns/1ns
module edge_detect (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       level_in,
    input  wire logic [1:0] sense,
    output logic            edge_seen
);
    logic last;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            last <= 1'b0;
        end else begin
            last <= level_in;
        end
    end

    // Combinational so the event reaches the flag in the same cycle
    always_comb begin
        unique case (sense)
            pwr_irq_pkg::EDGE_NONE: edge_seen = 1'b0;
            pwr_irq_pkg::EDGE_RISE: edge_seen = level_in & ~last;
            pwr_irq_pkg::EDGE_FALL: edge_seen = ~level_in & last;
            pwr_irq_pkg::EDGE_BOTH: edge_seen = level_in ^ last;
        endcase
    end
endmodule : edge_detect

// ---- rtl/power_policy_irq_status_mask.sv ----
// Top: event status, masks, edge configuration and interrupt output
`timescale 1ns/1ns
module power_policy_irq_status_mask (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        locked_event,
    input  wire logic        emulated_denial_event,
    input  wire logic        emulated_accept_event,
    input  wire logic        static_denial_event,
    input  wire logic        static_accept_event,
    input  wire logic        static_completion_event,
    input  wire logic        dynamic_denial_event,
    input  wire logic        dynamic_accept_event,
    input  wire logic        bad_policy_event,
    input  wire logic [10:0] mode_activity_inputs,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Registers written by software
    // ------------------------------------------------------------------
    logic [5:0]  main_mask;
    logic [2:0]  extra_event_mask;
    logic [21:0] edge_cfg;
    logic        main_wr;
    logic        extra_wr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            main_mask <= pwr_irq_pkg::MAIN_MASK_RST;
        end else if (reg_wr && hit(reg_addr, pwr_irq_pkg::MAIN_MASK_OFS)) begin
            main_mask <= reg_wdata[5:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            extra_event_mask <= pwr_irq_pkg::EXTRA_MASK_RST;
        end else if (reg_wr
                     && hit(reg_addr, pwr_irq_pkg::EXTRA_MASK_OFS)) begin
            extra_event_mask <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            edge_cfg <= pwr_irq_pkg::EDGE_CFG_RST;
        end else if (reg_wr && hit(reg_addr, pwr_irq_pkg::EDGE_CFG_OFS)) begin
            edge_cfg <= reg_wdata[21:0];
        end
    end

    assign main_wr  = reg_wr && hit(reg_addr, pwr_irq_pkg::STATUS_OFS);
    assign extra_wr = reg_wr && hit(reg_addr, pwr_irq_pkg::EXTRA_STAT_OFS);

    // ------------------------------------------------------------------
    // Main transition events
    // ------------------------------------------------------------------
    logic [5:0] main_ev;
    logic [5:0] main_flags;

    // Bit order locked down to static completion
    assign main_ev = {locked_event, emulated_denial_event,
                      emulated_accept_event, static_denial_event,
                      static_accept_event, static_completion_event};

    sticky_bits #(.W(6)) u_main (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .event_in   (main_ev),
        .mask       (main_mask),
        .clear_wr   (main_wr),
        .clear_data (reg_wdata[5:0]),
        .flags      (main_flags)
    );

    // ------------------------------------------------------------------
    // Extra events
    // ------------------------------------------------------------------
    logic [2:0] extra_ev;
    logic [2:0] extra_flags;

    assign extra_ev = {dynamic_denial_event, dynamic_accept_event,
                       bad_policy_event};

    // Only a write to the extra status register can clear these
    sticky_bits #(.W(3)) u_extra (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .event_in   (extra_ev),
        .mask       (extra_event_mask),
        .clear_wr   (extra_wr),
        .clear_data (reg_wdata[2:0]),
        .flags      (extra_flags)
    );

    // ------------------------------------------------------------------
    // Input edge events
    // ------------------------------------------------------------------
    logic [5:0] edge_ev;
    logic [5:0] edge_flags;
    logic [5:0] edge_clr;

    // Configuration slot n sits at bits 2*k+1..2*k of the input number k
    for (genvar n = 0; n < pwr_irq_pkg::EDGE_N; n++) begin : g_edge
        localparam int IN = int'(pwr_irq_pkg::EDGE_INPUT[n]);
        localparam int SB = int'(pwr_irq_pkg::EDGE_STAT_BIT[n]);
        edge_detect u_det (
            .sys_clk   (sys_clk),
            .rst       (rst),
            .level_in  (mode_activity_inputs[IN]),
            .sense     (edge_cfg[2*IN+1:2*IN]),
            .edge_seen (edge_ev[n])
        );
        assign edge_clr[n] = reg_wdata[SB];
    end

    // Edge flags have no mask of their own: the 00 setting masks them
    sticky_bits #(.W(6)) u_edges (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .event_in   (edge_ev),
        .mask       (6'h00),
        .clear_wr   (main_wr),
        .clear_data (edge_clr),
        .flags      (edge_flags)
    );

    // ------------------------------------------------------------------
    // Status word assembly
    // ------------------------------------------------------------------
    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h00000000;
        status_word[5:0] = main_flags;
        // Summary bit is derived, so a main write can never clear it
        status_word[pwr_irq_pkg::OTHER_BIT] = |extra_flags;
        for (int n = 0; n < pwr_irq_pkg::EDGE_N; n++) begin
            status_word[pwr_irq_pkg::EDGE_STAT_BIT[n]] = edge_flags[n];
        end
    end

    // ------------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------------
    // Registered from the flags, so it trails them by one cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= (|status_word) | (|extra_flags);
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h00000000;
        if (reg_rd) begin
            unique case (reg_addr)
                pwr_irq_pkg::MAIN_MASK_OFS:
                    next_rdata[5:0] = main_mask;
                pwr_irq_pkg::EXTRA_MASK_OFS:
                    next_rdata[2:0] = extra_event_mask;
                pwr_irq_pkg::STATUS_OFS:
                    next_rdata = status_word;
                pwr_irq_pkg::EXTRA_STAT_OFS:
                    next_rdata[2:0] = extra_flags;
                pwr_irq_pkg::EDGE_CFG_OFS:
                    next_rdata[21:0] = edge_cfg;
                pwr_irq_pkg::EVENT_IN_OFS:
                    next_rdata[10:0] = mode_activity_inputs;
                default:
                    next_rdata = 32'h00000000;
            endcase
        end
    end

    // Unmapped or idle cycles read zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule : power_policy_irq_status_mask

// ---- verif/pwr_irq_monitor.sv ----
// Checker: read-back and interrupt timing of the event block
`timescale 1ns/1ns
module pwr_irq_monitor (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        locked_event,
    input wire logic        emulated_denial_event,
    input wire logic        emulated_accept_event,
    input wire logic        static_denial_event,
    input wire logic        static_accept_event,
    input wire logic        static_completion_event,
    input wire logic        dynamic_denial_event,
    input wire logic        dynamic_accept_event,
    input wire logic        bad_policy_event,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------
    // Mask shadows rebuilt from bus writes
    // ------------------------------------------
    logic [5:0] mm;
    logic [2:0] xm;
    logic [7:0] pa;
    logic [5:0] mev;
    logic [2:0] xev;
    assign mev = {locked_event, emulated_denial_event,
                  emulated_accept_event, static_denial_event,
                  static_accept_event, static_completion_event};
    assign xev = {dynamic_denial_event, dynamic_accept_event,
                  bad_policy_event};
    // No read marks pa as 8'hff, an address nobody uses
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mm <= pwr_irq_pkg::MAIN_MASK_RST;
            xm <= pwr_irq_pkg::EXTRA_MASK_RST;
            pa <= 8'hff;
        end else begin
            pa <= reg_rd ? reg_addr : 8'hff;
            if (reg_wr && reg_addr == pwr_irq_pkg::MAIN_MASK_OFS)
                mm <= reg_wdata[5:0];
            if (reg_wr && reg_addr == pwr_irq_pkg::EXTRA_MASK_OFS)
                xm <= reg_wdata[2:0];
        end
    end
    // ------------------------------------------
    // Assertions
    // ------------------------------------------
    a_idle_read_zero: assert property (pa == 8'hff |-> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_main_rsvd_zero: assert property (
        pa == pwr_irq_pkg::STATUS_OFS |-> (reg_rdata & 32'hfff85d40) == 0)
        else $error("reserved status bit read as one");
    a_extra_rsvd_zero: assert property (
        pa == pwr_irq_pkg::EXTRA_STAT_OFS |-> reg_rdata[31:3] == 29'h0)
        else $error("reserved extra status bit read as one");
    // Read data show the state of the read edge, so a write on that same edge as
    // the read must not leak into the expected value
    a_xmask_read_back: assert property (
        pa == pwr_irq_pkg::EXTRA_MASK_OFS |-> reg_rdata == {29'h0, $past(xm)})
        else $error("extra mask read-back wrong");
    a_mmask_read_back: assert property (
        pa == pwr_irq_pkg::MAIN_MASK_OFS |-> reg_rdata == {26'h0, $past(mm)})
        else $error("main mask read-back wrong");
    // The interrupt and the read data both trail the same flags by one edge
    a_irq_tracks_status: assert property (
        pa == pwr_irq_pkg::STATUS_OFS |-> $past(irq) == (reg_rdata != 32'h0))
        else $error("interrupt disagrees with status");
    a_main_event_irq: assert property (
        |(mev & ~mm) |-> ##2 irq)
        else $error("unmasked event gave no interrupt");
    a_extra_event_irq: assert property (
        |(xev & ~xm) |-> ##2 irq)
        else $error("unmasked extra event gave no interrupt");
    a_irq_holds_high: assert property (
        irq && !$past(reg_wr) |=> irq)
        else $error("interrupt dropped without a clear");
endmodule : pwr_irq_monitor

bind power_policy_irq_status_mask pwr_irq_monitor u_mon (.*);

// ---- verif/tb.sv ----
// Testbench: random and corner traffic against the event block
`timescale 1ns/1ns
module tb;
    logic        sys_clk;
    logic        rst;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [10:0] mode_activity_inputs;
    logic        irq;
    logic [8:0]  ev;
    logic        locked_event, emulated_denial_event;
    logic        emulated_accept_event, static_denial_event;
    logic        static_accept_event, static_completion_event;
    logic        dynamic_denial_event, dynamic_accept_event;
    logic        bad_policy_event;
    logic [5:0]  mm, mst, est;
    logic [2:0]  xm, xst;
    logic [31:0] cfg;
    int          n_errors = 0;
    int          total_checks = 0;
    int          cyc = 0;
    assign {locked_event, emulated_denial_event, emulated_accept_event,
            static_denial_event, static_accept_event,
            static_completion_event, dynamic_denial_event,
            dynamic_accept_event, bad_policy_event} = ev;
    power_policy_irq_status_mask dut (.*);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Cuts a hang short well after the planned traffic
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            end_of_test();
        end
    end
    // ------------------------------------------
    // Model and bus tasks
    // ------------------------------------------
    // Events set with the old masks, then the write lands; set beats clear
    function void upd(input logic [7:0] a, input logic [31:0] d,
                      input logic [8:0] e);
        logic [5:0] sm;
        logic [2:0] sx;
        sm = e[8:3] & ~mm;
        sx = e[2:0] & ~xm;
        case (a)
            8'h30: mm = d[5:0];
            8'h34: xm = d[2:0];
            8'h38: begin
                mst &= ~d[5:0];
                est &= ~{d[18:15], d[13], d[9]};
            end
            8'h3c: xst &= ~d[2:0];
            default: ;
        endcase
        mst |= sm;
        xst |= sx;
    endfunction : upd
    function logic [31:0] st();
        return {13'h0, est[5:2], 1'b0, est[1], 3'h0, est[0], 1'b0,
                |xst, 1'b0, mst};
    endfunction : st
    task chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [8:0] e);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        ev <= e;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        ev <= 9'h0;
        upd(a, d, e);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd
    task end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    // ------------------------------------------
    // Tests
    // ------------------------------------------
    initial begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata, ev} = '0;
        rst = 1'b1;
        mode_activity_inputs = 11'h0;
        {mm, xm, mst, xst, est} = {6'h3b, 3'h6, 15'h0};
        void'($urandom(3));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h30, 32'h3b);
        rd(8'h34, 32'h6);
        rd(8'h38, 32'h0);
        rd(8'h3c, 32'h0);
        rd(8'h50, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 60; i++) begin
            wr(8'h30 + 8'($urandom_range(3) * 4), $urandom, 9'($urandom));
            rd(8'h38, st());
            rd(8'h3c, {29'h0, xst});
            chk({31'h0, irq}, {31'h0, |st()});
        end
        $display("test random traffic done");
        wr(8'h30, 32'h0, 9'h0);
        wr(8'h34, 32'h0, 9'h0);
        wr(8'h38, 32'hffffffff, 9'h1ff);
        rd(8'h38, st());
        wr(8'h38, 32'hffffffff, 9'h0);
        wr(8'h3c, 32'hffffffff, 9'h0);
        rd(8'h38, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test clear collision done");
        for (int c = 0; c < 4; c++) begin
            cfg = '0;
            for (int k = 0; k < 6; k++)
                cfg[2 * pwr_irq_pkg::EDGE_INPUT[k] +: 2] = c[1:0];
            wr(8'h40, cfg, 9'h0);
            rd(8'h40, cfg);
            for (int lv = 0; lv < 2; lv++) begin
                @(posedge sys_clk);
                mode_activity_inputs <= lv ? 11'h0 : 11'h7ff;
                est = c[lv] ? 6'h3f : 6'h0;
                repeat (3) @(posedge sys_clk);
                rd(8'h38, st());
                rd(8'h44, lv ? 32'h0 : 32'h7ff);
                wr(8'h38, 32'hffffffff, 9'h0);
            end
        end
        $display("test edge settings done");
        end_of_test();
    end
endmodule : tb
